// >>> fsr2_consts.vh
/*
  Constants for the second status register of the serial flash: bit positions,
  reset value, command opcodes and masks.
  Assumes it is included by bare name from the design files of this block.
*/
// Functional notes
// - Suspend command sets the read-only suspend flag in bit 7; resets to 0.
// - Resume, hardware reset, JEDEC reset or 66h/99h pair clear the suspend flag.
// - Bit 6 complement bit, reset 0, inverts the block-protection map when 1.
// - Lock flags 5:3 set by hardware on programming byte 127 (7Fh), the last byte of the register.
// - Register 3 lock in bit 5, register 2 in bit 4, register 1 in bit 3.
// - A set lock flag makes its security register permanently read-only; core reset here clears the flags.
// - Factory security register 0 is always treated as locked.
// - Quad enable bit 1 resets 0; at 0 the protect and hold pins keep their roles.
// - Quad enable at 1 turns those pins into data lanes two and three.
// - Quad enable gates the six quad commands as well as the pin roles; host sets it first.
// - Register written only after the write permit latch and when protection allows.
`ifndef FSR2_CONSTS_VH
`define FSR2_CONSTS_VH

// ----------------------------------------------------------------------------
// Register layout
// ----------------------------------------------------------------------------
`define FSR2_BIT_SUSPEND 7
`define FSR2_BIT_COMPLEMENT 6
`define FSR2_BIT_LOCK3 5
`define FSR2_BIT_LOCK2 4
`define FSR2_BIT_LOCK1 3
`define FSR2_BIT_RESERVED 2
`define FSR2_BIT_QUAD 1
`define FSR2_RESET_VALUE 8'h00
`define FSR2_WRITE_MASK 8'h42

// ----------------------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------------------
`define FSR2_OP_WRITE_ENABLE 8'h06
`define FSR2_OP_READ_STATUS2 8'h35
`define FSR2_OP_WRITE_STATUS2 8'h31
`define FSR2_OP_SUSPEND 8'h75
`define FSR2_OP_RESUME 8'h7A
`define FSR2_OP_RESET_ENABLE 8'h66
`define FSR2_OP_RESET 8'h99
`define FSR2_OP_QUAD_OUT_READ 8'h6B
`define FSR2_OP_XIP_READ 8'hEB
`define FSR2_OP_QUAD_ALIGNED_READ 8'hE7
`define FSR2_OP_QUAD_PROGRAM 8'h32
`define FSR2_OP_BURST_WRAP 8'h77
`define FSR2_OP_QUAD_ID_READ 8'h94
`define FSR2_SEC_LAST_BYTE 7'h7F

`endif

// >>> fsr2_sync.v
/*
  Two-flop synchroniser for one level from outside the core clock domain.
  Assumes the core clock is at least a few times faster than the input changes.
*/
module fsr2_sync #(
  parameter [0:0] RESET_VAL = 1'b0
) (
  input wire core_clk,
  input wire reset,
  input wire async_in,
  output wire sync_out
);

  reg meta_ff;
  reg sync_ff;

  // The first stage is read only by the second stage. Both reset to the pin's idle
  // level, so an edge detector behind this stage sees no false edge after reset.
  always @(posedge core_clk) begin
    if (reset) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// >>> fsr2_status_reg.v
/*
  Second status register of a serial flash, with its own SPI command front end.
  Sampled SPI mode 0: serial clock, select and input lanes are synchronised to
  core_clk, which must run several times faster than the serial clock.
  Assumes the program engine reports security-register byte programs and the
  protect logic supplies the write-protect verdict and the write permit latch.
*/
module fsr2_status_reg (
  input wire core_clk,
  input wire reset,
  input wire spi_clk,
  input wire spi_cs_n,
  input wire spi_mosi,
  input wire hold_reset_n_pin,
  input wire write_protect_n_pin,
  input wire jedec_reset,
  input wire write_permit_latch,
  input wire status_write_allowed,
  input wire sec_prog_strobe,
  input wire [1:0] sec_prog_index,
  input wire [6:0] sec_prog_byte,
  output reg spi_miso,
  output reg spi_miso_oe,
  output reg suspend_flag,
  output reg complement_protect,
  output reg [2:0] security_lock_flags,
  output reg quad_lane_enable,
  output reg sec_prog_refused,
  output reg hold_active,
  output reg write_protect_active,
  output reg data_lane_two,
  output reg data_lane_three,
  output reg quad_cmd_accept,
  output reg quad_cmd_refused,
  output reg status_written
);

`include "fsr2_consts.vh"

  localparam ST_IDLE = 2'd0;
  localparam ST_DATA = 2'd1;
  localparam ST_READ = 2'd2;
  localparam ST_SKIP = 2'd3;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  wire sclk_s;
  wire cs_n_s;
  wire mosi_s;
  wire hold_s;
  wire wp_s;
  wire jrst_s;

  fsr2_sync u_sync_sclk (.core_clk(core_clk), .reset(reset), .async_in(spi_clk),
    .sync_out(sclk_s));
  fsr2_sync #(.RESET_VAL(1'b1)) u_sync_cs (.core_clk(core_clk), .reset(reset),
    .async_in(spi_cs_n), .sync_out(cs_n_s));
  fsr2_sync u_sync_mosi (.core_clk(core_clk), .reset(reset), .async_in(spi_mosi),
    .sync_out(mosi_s));
  fsr2_sync #(.RESET_VAL(1'b1)) u_sync_hold (.core_clk(core_clk), .reset(reset),
    .async_in(hold_reset_n_pin), .sync_out(hold_s));
  fsr2_sync #(.RESET_VAL(1'b1)) u_sync_wp (.core_clk(core_clk), .reset(reset),
    .async_in(write_protect_n_pin), .sync_out(wp_s));
  fsr2_sync u_sync_jrst (.core_clk(core_clk), .reset(reset), .async_in(jedec_reset),
    .sync_out(jrst_s));

  // --------------------------------------------------------------------------
  // Serial clock edges and byte shifter
  // --------------------------------------------------------------------------
  reg sclk_d_ff;
  reg hold_d_ff;
  reg [7:0] shift_ff;
  reg [2:0] bit_cnt_ff;
  reg [1:0] state_ff;
  reg [7:0] rd_shift_ff;
  reg reset_armed_ff;
  wire sclk_rise;
  wire sclk_fall;
  wire byte_done;
  wire [7:0] rx_byte;
  wire [7:0] status_view;
  wire hold_reset_evt;
  wire is_quad_op;
  wire sec_locked;

  assign sclk_rise = sclk_s & ~sclk_d_ff & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_d_ff & ~cs_n_s;
  assign rx_byte = {shift_ff[6:0], mosi_s};
  assign byte_done = sclk_rise & (bit_cnt_ff == 3'd7);
  // Reserved bit 2 and bit 0 always read as zero.
  assign status_view = {suspend_flag, complement_protect, security_lock_flags,
    1'b0, quad_lane_enable, 1'b0};
  // Hold pin acts as hardware reset only while quad lanes are off.
  assign hold_reset_evt = ~hold_s & hold_d_ff & ~quad_lane_enable;
  assign is_quad_op = (rx_byte == `FSR2_OP_QUAD_OUT_READ) ||
    (rx_byte == `FSR2_OP_XIP_READ) || (rx_byte == `FSR2_OP_QUAD_ALIGNED_READ) ||
    (rx_byte == `FSR2_OP_QUAD_PROGRAM) || (rx_byte == `FSR2_OP_BURST_WRAP) ||
    (rx_byte == `FSR2_OP_QUAD_ID_READ);
  // Register 0 is factory locked; registers 1..3 follow their flags.
  assign sec_locked = (sec_prog_index == 2'd0) ? 1'b1 :
    security_lock_flags[sec_prog_index - 2'd1];

  // Command front end: one opcode byte, then data or read-back.
  always @(posedge core_clk) begin
    if (reset) begin
      sclk_d_ff <= 1'b0;
      hold_d_ff <= 1'b1;
      shift_ff <= 8'h00;
      bit_cnt_ff <= 3'd0;
      state_ff <= ST_IDLE;
      rd_shift_ff <= 8'h00;
      reset_armed_ff <= 1'b0;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
      hold_d_ff <= hold_s;
      if (cs_n_s) begin
        bit_cnt_ff <= 3'd0;
        state_ff <= ST_IDLE;
        spi_miso_oe <= 1'b0;
      end else begin
        if (sclk_rise) begin
          shift_ff <= rx_byte;
          bit_cnt_ff <= bit_cnt_ff + 3'd1;
        end
        if (byte_done && state_ff == ST_IDLE) begin
          reset_armed_ff <= (rx_byte == `FSR2_OP_RESET_ENABLE);
          if (rx_byte == `FSR2_OP_READ_STATUS2) begin
            state_ff <= ST_READ;
            rd_shift_ff <= status_view;
          end else if (rx_byte == `FSR2_OP_WRITE_STATUS2) begin
            state_ff <= ST_DATA;
          end else begin
            state_ff <= ST_SKIP;
          end
        end
        // Status read repeats the register until select rises.
        if (state_ff == ST_READ && sclk_fall) begin
          spi_miso <= rd_shift_ff[7];
          spi_miso_oe <= 1'b1;
          if (bit_cnt_ff == 3'd0) begin
            rd_shift_ff <= {status_view[6:0], 1'b0};
            spi_miso <= status_view[7];
          end else begin
            rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
          end
        end
        if (byte_done && state_ff == ST_DATA) begin
          state_ff <= ST_SKIP;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status bits and pin roles
  // --------------------------------------------------------------------------
  wire op_done;
  wire wr_ok;

  assign op_done = byte_done && state_ff == ST_IDLE;
  assign wr_ok = byte_done && state_ff == ST_DATA && write_permit_latch &&
    status_write_allowed;

  // Suspend set/clear, lock flags, writable bits; set wins over a same-cycle clear.
  always @(posedge core_clk) begin
    if (reset) begin
      suspend_flag <= 1'b0;
      complement_protect <= 1'b0;
      security_lock_flags <= 3'b000;
      quad_lane_enable <= 1'b0;
      sec_prog_refused <= 1'b0;
      quad_cmd_accept <= 1'b0;
      quad_cmd_refused <= 1'b0;
      status_written <= 1'b0;
    end else begin
      sec_prog_refused <= 1'b0;
      quad_cmd_accept <= 1'b0;
      quad_cmd_refused <= 1'b0;
      status_written <= 1'b0;
      if (hold_reset_evt || jrst_s ||
          (op_done && rx_byte == `FSR2_OP_RESUME) ||
          (op_done && rx_byte == `FSR2_OP_RESET && reset_armed_ff)) begin
        suspend_flag <= 1'b0;
      end
      if (op_done && rx_byte == `FSR2_OP_SUSPEND) begin
        suspend_flag <= 1'b1;
      end
      if (op_done && is_quad_op) begin
        quad_cmd_accept <= quad_lane_enable;
        quad_cmd_refused <= ~quad_lane_enable;
      end
      if (sec_prog_strobe) begin
        if (sec_locked) begin
          sec_prog_refused <= 1'b1;
        end else if (sec_prog_byte == `FSR2_SEC_LAST_BYTE) begin
          security_lock_flags[sec_prog_index - 2'd1] <= 1'b1;
        end
      end
      // Only complement and quad bits take written data.
      if (wr_ok) begin
        complement_protect <= rx_byte[`FSR2_BIT_COMPLEMENT];
        quad_lane_enable <= rx_byte[`FSR2_BIT_QUAD];
        status_written <= 1'b1;
      end
    end
  end

  // Pin roles follow the quad enable bit; control roles are dropped in quad mode.
  always @(posedge core_clk) begin
    if (reset) begin
      hold_active <= 1'b0;
      write_protect_active <= 1'b0;
      data_lane_two <= 1'b0;
      data_lane_three <= 1'b0;
    end else begin
      hold_active <= ~quad_lane_enable & ~hold_s;
      write_protect_active <= ~quad_lane_enable & ~wp_s;
      data_lane_two <= quad_lane_enable & wp_s;
      data_lane_three <= quad_lane_enable & hold_s;
    end
  end

endmodule

// >>> fsr2_status_reg_chk.sv
/* Port checker for the second status register block.
   Bound to fsr2_status_reg from the bench top file; sees only its ports. */
module fsr2_chk (
  input wire core_clk,
  input wire reset,
  input wire jedec_reset,
  input wire write_permit_latch,
  input wire status_write_allowed,
  input wire sec_prog_strobe,
  input wire [1:0] sec_prog_index,
  input wire suspend_flag,
  input wire complement_protect,
  input wire [2:0] security_lock_flags,
  input wire quad_lane_enable,
  input wire sec_prog_refused,
  input wire hold_active,
  input wire write_protect_active,
  input wire quad_cmd_accept,
  input wire quad_cmd_refused,
  input wire status_written
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // The reset check overrides the default disable, since reset is its cause.
  a_reset_clear: assert property (disable iff (1'b0) reset |=>
    {suspend_flag, complement_protect, security_lock_flags, quad_lane_enable} == 6'h00)
    else $error("flags not clear after reset");
  a_lock_sticky: assert property (
    ($past(security_lock_flags) & ~security_lock_flags) == 3'h0) else $error("lock fell");
  a_reg0_refused: assert property (
    sec_prog_strobe && sec_prog_index == 2'h0 |-> ##[1:3] sec_prog_refused)
    else $error("register 0 program not refused");
  a_quad_gate: assert property ((quad_cmd_accept |-> quad_lane_enable) and
    (quad_cmd_refused |-> !quad_lane_enable)) else $error("quad gating wrong");
  a_lane_roles: assert property (
    quad_lane_enable && $past(quad_lane_enable) |-> !hold_active && !write_protect_active)
    else $error("control role active in quad mode");
  a_write_guard: assert property (
    status_written |-> $past(write_permit_latch && status_write_allowed))
    else $error("bad write");
  a_bits_cause: assert property (
    $changed({complement_protect, quad_lane_enable}) |-> status_written || $past(status_written))
    else $error("writable bit changed without a write");
  a_jedec_clear: assert property (jedec_reset [*4] |=> !suspend_flag)
    else $error("suspend held through jedec reset");
endmodule

// >>> fsr2_host.sv
/* SPI mode 0 host model issuing whole command frames.
   Assumes core_clk runs eight times per serial bit; the serial clock stands low between frames. */
module fsr2_host (
  input wire core_clk,
  input wire spi_miso,
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end
  // One half period of the serial clock is four core cycles, 800 ns a bit.
  task automatic half();
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  // Miso is taken late in the high phase, since the device moves it on the fall.
  task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input int n,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {op, dat};
    half();
    spi_cs_n = 1'b0;
    for (int i = 0; i < 8 * n; i++) begin
      spi_mosi = sh[15 - i];
      half();
      spi_clk = 1'b1;
      half();
      rd = {rd[6:0], spi_miso};
      spi_clk = 1'b0;
    end
    half();
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // A released line must not keep its last value.
    half();
  endtask
endmodule

// >>> fsr2_status_reg_bench.sv
/* Self-checking bench for fsr2_status_reg with the SPI host model.
   Assumes the constants header, the design, the host and the checker files. */
`include "fsr2_consts.vh"
module fsr2_status_reg_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, reset = 1'b1, jedec_reset = 1'b0, sec_prog_strobe = 1'b0;
  logic hold_reset_n_pin = 1'b1, write_protect_n_pin = 1'b1;
  logic write_permit_latch = 1'b1, status_write_allowed = 1'b1, s_e = 1'b0, c_e = 1'b0;
  logic q_e = 1'b0, oe_seen = 1'b0;
  logic [1:0] sec_prog_index = 2'h0;
  logic [6:0] sec_prog_byte = 7'h00;
  logic [2:0] locks = 3'h0;
  logic [7:0] rd;
  logic [31:0] seed = 32'h813707CD;
  logic [7:0] quad_ops [6] = '{`FSR2_OP_QUAD_OUT_READ, `FSR2_OP_XIP_READ,
    `FSR2_OP_QUAD_ALIGNED_READ, `FSR2_OP_QUAD_PROGRAM, `FSR2_OP_BURST_WRAP,
    `FSR2_OP_QUAD_ID_READ};
  wire spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, suspend_flag, quad_lane_enable;
  wire complement_protect, sec_prog_refused, hold_active, write_protect_active;
  wire data_lane_two, data_lane_three, quad_cmd_accept, quad_cmd_refused, status_written;
  wire [2:0] security_lock_flags;
  int error_cnt = 0, tests_run = 0, cyc = 0, n_acc = 0, n_ref = 0, n_spr = 0, e_spr = 0;
  int n_wr = 0;
  fsr2_status_reg i_dut (.core_clk(core_clk), .reset(reset), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .hold_reset_n_pin(hold_reset_n_pin),
    .write_protect_n_pin(write_protect_n_pin), .jedec_reset(jedec_reset),
    .write_permit_latch(write_permit_latch), .status_write_allowed(status_write_allowed),
    .sec_prog_strobe(sec_prog_strobe), .sec_prog_index(sec_prog_index),
    .sec_prog_byte(sec_prog_byte), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .suspend_flag(suspend_flag), .complement_protect(complement_protect),
    .security_lock_flags(security_lock_flags), .quad_lane_enable(quad_lane_enable),
    .sec_prog_refused(sec_prog_refused), .hold_active(hold_active),
    .write_protect_active(write_protect_active), .data_lane_two(data_lane_two),
    .data_lane_three(data_lane_three), .quad_cmd_accept(quad_cmd_accept),
    .quad_cmd_refused(quad_cmd_refused), .status_written(status_written));
  fsr2_host i_host (.core_clk(core_clk), .spi_miso(spi_miso), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
  always #50 core_clk = ~core_clk;
  // Pulse counters; the cycle ceiling cuts a hang short.
  always @(posedge core_clk) begin
    cyc++;
    n_acc += quad_cmd_accept;
    n_ref += quad_cmd_refused;
    n_spr += sec_prog_refused;
    n_wr += status_written;
    oe_seen |= spi_miso_oe;
    if (cyc == 30000) begin
      error_cnt++;
      close_out();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int n);
    i_host.xfer(op, d, n, rd);
    tick(6);
  endtask
  // The read must have driven miso and released it again once select rose.
  task automatic rd_chk();
    oe_seen = 1'b0;
    i_host.xfer(`FSR2_OP_READ_STATUS2, 8'h00, 2, rd);
    check("status_two", {s_e, c_e, locks, 1'b0, q_e, 1'b0}, rd);
    check("miso_oe", 8'h02, {6'h00, oe_seen, spi_miso_oe});
  endtask
  task automatic prog(input logic [1:0] idx, input logic [6:0] b);
    sec_prog_index = idx;
    sec_prog_byte = b;
    sec_prog_strobe = 1'b1;
    tick(1);
    sec_prog_strobe = 1'b0;
    tick(4);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence: writes, pin roles, quad gating, suspend clearing, locks.
  initial begin
    repeat (16) @(posedge core_clk);
    #1 reset = 1'b0;
    tick(4);
    rd_chk();
    cmd(`FSR2_OP_WRITE_STATUS2, 8'hFF, 2);
    {c_e, q_e} = 2'b11;
    rd_chk();
    repeat (4) begin
      seed = lfsr(seed);
      {hold_reset_n_pin, write_protect_n_pin} = seed[1:0];
      tick(6);
      check("lanes", {6'h00, seed[1:0]}, {hold_active, write_protect_active,
        data_lane_three, data_lane_two});
    end
    {hold_reset_n_pin, write_protect_n_pin} = 2'b11;
    foreach (quad_ops[k]) cmd(quad_ops[k], 8'h00, 1);
    check("quad accepts", 8'h06, n_acc);
    cmd(`FSR2_OP_WRITE_STATUS2, 8'hBD, 2);
    {c_e, q_e} = 2'b00;
    rd_chk();
    foreach (quad_ops[k]) cmd(quad_ops[k], 8'h00, 1);
    check("quad refusals", 8'h06, n_ref);
    for (int i = 0; i < 3; i++) begin
      {write_permit_latch, status_write_allowed} = i[1:0];
      cmd(`FSR2_OP_WRITE_STATUS2, 8'hFF, 2);
      rd_chk();
    end
    {write_permit_latch, status_write_allowed} = 2'b11;
    check("writes", 8'h02, n_wr);
    for (int m = 0; m < 4; m++) begin
      cmd(`FSR2_OP_SUSPEND, 8'h00, 1);
      s_e = 1'b1;
      rd_chk();
      case (m)
        0: cmd(`FSR2_OP_RESUME, 8'h00, 1);
        1: begin
          jedec_reset = 1'b1;
          tick(6);
          jedec_reset = 1'b0;
        end
        2: begin
          cmd(`FSR2_OP_RESET_ENABLE, 8'h00, 1);
          cmd(`FSR2_OP_RESET, 8'h00, 1);
        end
        default: begin
          {hold_reset_n_pin, write_protect_n_pin} = 2'b00;
          tick(6);
          check("pin roles", 8'h03, {hold_active, write_protect_active});
          {hold_reset_n_pin, write_protect_n_pin} = 2'b11;
        end
      endcase
      tick(6);
      s_e = 1'b0;
      rd_chk();
    end
    // A reset opcode without the enable just before it must leave suspend set.
    cmd(`FSR2_OP_SUSPEND, 8'h00, 1);
    cmd(`FSR2_OP_RESET, 8'h00, 1);
    s_e = 1'b1;
    rd_chk();
    cmd(`FSR2_OP_RESUME, 8'h00, 1);
    s_e = 1'b0;
    // Registers 1 to 3 lock only on their last byte; register 0 never programs.
    for (int r = 0; r < 4; r++) begin
      seed = lfsr(seed);
      prog(r[1:0], seed[6:0] % 7'h7F);
      prog(r[1:0], `FSR2_SEC_LAST_BYTE);
      if (r != 0) locks[r - 1] = 1'b1;
      prog(r[1:0], seed[6:0]);
      e_spr += (r == 0) ? 3 : 1;
      check("sec refusals", e_spr[7:0], n_spr);
    end
    rd_chk();
    close_out();
  end
endmodule
bind fsr2_status_reg fsr2_chk i_chk (.core_clk(core_clk), .reset(reset),
  .jedec_reset(jedec_reset), .write_permit_latch(write_permit_latch),
  .status_write_allowed(status_write_allowed), .sec_prog_strobe(sec_prog_strobe),
  .sec_prog_index(sec_prog_index), .suspend_flag(suspend_flag),
  .complement_protect(complement_protect), .security_lock_flags(security_lock_flags),
  .quad_lane_enable(quad_lane_enable), .sec_prog_refused(sec_prog_refused),
  .hold_active(hold_active), .write_protect_active(write_protect_active),
  .quad_cmd_accept(quad_cmd_accept), .quad_cmd_refused(quad_cmd_refused),
  .status_written(status_written));
